// >>> led_bank_defs.vh
// constants of the led driver register bank
`ifndef LED_BANK_DEFS_VH
`define LED_BANK_DEFS_VH
// How it works
// - every register is eight bits wide
// - answers target address 0x28 or 0x29
// - read-only bits ignore writes, rw bits hold
// - offset zero resets 0x2B, frequency select
// - shutdown bit lets faults clear device enable
// - gate drive setting passed out unchanged
// - offset one resets 0x5E, bit seven rw
// - bit six enables the on-time limit
// - limit is 700 plus 200 per code
// - expired limit blocks sinks until next rise
// - initial vout code passed out unchanged
// - offset two resets zero, upper bits rw
// - three-bit initial peak current select
// - fault clears channel enable, maybe device enable
// - gate one drives channels 1-3, two 4-6

// target addresses of the two variants
`define ADDR_VARIANT_A 7'h28
`define ADDR_VARIANT_B 7'h29

// register offsets
`define OFS_PRECHARGE 8'h00
`define OFS_VOUT 8'h01
`define OFS_PEAK 8'h02
`define OFS_G1_HIGH 8'h03
`define OFS_G1_LOW 8'h04
`define OFS_G2_HIGH 8'h05
`define OFS_G2_LOW 8'h06
`define OFS_CH_EN 8'h07
`define OFS_MODE 8'h08
`define OFS_BOOST 8'h09
`define OFS_LED 8'h10

// reset values
`define RST_PRECHARGE 8'h2B
`define RST_VOUT 8'h5E
`define RST_PEAK 8'h00
`define RST_G_HIGH 8'h02
`define RST_G_LOW 8'hBC
`define RST_CH_EN 8'h00
`define RST_MODE 8'h13
`define RST_BOOST 8'h06
`define RST_LED 8'h00

// field positions
`define FSW_LSB 4
`define FAULT_SD_BIT 3
`define TMO_EN_BIT 6
`define TMO_LSB 3
`define DRV_FAST_BIT 7
`define DEVICE_ON_INTERNAL_BIT 6
`define COMP_LSB 3
`define SUPPLY_BIT 7
`define SHORT_FLAG_BIT 7
`define OPEN_FLAG_BIT 6

// timing: internal clock rate and the on-time limit in its cycles
`define CLK_FREQ_HZ 100000000
`define INT_CLK_HZ 500000
// clock cycles per internal tick, CLK_FREQ_HZ over INT_CLK_HZ
`define TICK_DIV_CYCLES 16'h00C8
`define PWM_TMO_BASE 12'h2BC
`define PWM_TMO_STEP 12'h0C8

`endif

// >>> pwm_on_time_gate.v
// one pwm group gate with on-time limit
`timescale 1ns/100ps
`default_nettype none
module pwm_on_time_gate #(
    parameter CNT_W = 12
) (
    input wire clk_i,
    input wire rst_i,
    input wire pwm_i,
    input wire tick_i,
    input wire limit_en_i,
    input wire [CNT_W-1:0] limit_i,
    output reg gate_o
);

reg pwm_d_r;
reg blocked_r;
reg [CNT_W-1:0] cnt_r;
wire rise;
wire [CNT_W-1:0] cnt_nxt;

assign rise = pwm_i & ~pwm_d_r;
assign cnt_nxt = cnt_r + {{(CNT_W-1){1'b0}}, 1'b1};

always @(posedge clk_i)
begin
    if (rst_i)
    begin
        pwm_d_r <= 1'b0;
        blocked_r <= 1'b0;
        cnt_r <= {CNT_W{1'b0}};
        gate_o <= 1'b0;
    end
    else
    begin
        pwm_d_r <= pwm_i;
        if (rise)
        begin
            cnt_r <= {CNT_W{1'b0}};
            blocked_r <= 1'b0;
        end
        else if (pwm_i && !blocked_r && tick_i && cnt_r != {CNT_W{1'b1}})
        begin
            cnt_r <= cnt_nxt;
            // once blocked, only a fresh rising edge lets current flow again
            if (limit_en_i && cnt_nxt >= limit_i)
            begin
                blocked_r <= 1'b1;
            end
        end
        gate_o <= pwm_i & (rise | ~blocked_r);
    end
end

endmodule // pwm_on_time_gate
`default_nettype wire

// >>> led_driver_i2c_register_bank.v
// i2c target and register bank of the six-channel led driver
`timescale 1ns/100ps
`default_nettype none
`include "led_bank_defs.vh"
module led_driver_i2c_register_bank #(
    parameter ADDR_SEL = 0,
    parameter [15:0] TICK_DIV = `TICK_DIV_CYCLES
) (
    input wire CLK_I,
    input wire RST_I,
    input wire SCL_I,
    input wire SDA_I,
    output wire SDA_O,
    output wire SDA_OE_O,
    input wire GROUP_ONE_GATE_IN_I,
    input wire GROUP_TWO_GATE_IN_I,
    input wire [5:0] CHANNEL_FAULT_I,
    input wire STRING_SHORT_I,
    input wire STRING_OPEN_I,
    input wire OVERCURRENT_I,
    input wire OVERVOLTAGE_I,
    input wire OUTPUT_SHORT_I,
    input wire OVERTEMP_I,
    output wire [5:0] SINK_DRIVE_O,
    output wire [1:0] SWITCH_FREQ_SEL_O,
    output wire [2:0] GATE_DRIVE_LEVEL_O,
    output wire [2:0] INITIAL_VOUT_SEL_O,
    output wire [2:0] INITIAL_PEAK_SEL_O,
    output wire [9:0] GROUP_ONE_CURRENT_CODE_O,
    output wire [9:0] GROUP_TWO_CURRENT_CODE_O,
    output wire DRIVER_FAST_O,
    output wire DEVICE_ON_INTERNAL_O,
    output wire [2:0] COMP_RESISTOR_SEL_O,
    output wire [2:0] LOOP_GAIN_SEL_O,
    output wire SUPPLY_SOURCE_SEL_O,
    output wire [2:0] OVERVOLTAGE_LIMIT_SEL_O
);

// ------------------------------------------------------------
// states and constants
// ------------------------------------------------------------
localparam [3:0] ST_IDLE = 4'h0, ST_ADDR = 4'h1, ST_ACK_ADDR = 4'h2;
localparam [3:0] ST_OFFS = 4'h3, ST_ACK_OFFS = 4'h4, ST_WDATA = 4'h5;
localparam [3:0] ST_ACK_W = 4'h6, ST_RDATA = 4'h7, ST_RACK = 4'h8;
localparam [6:0] DEV_ADDR = (ADDR_SEL != 0) ? `ADDR_VARIANT_B : `ADDR_VARIANT_A;
localparam [15:0] TICK_LAST = TICK_DIV - 16'h0001;

function [11:0] limit_ticks;
    input [2:0] code;
    begin
        limit_ticks = `PWM_TMO_BASE + ({9'h000, code} * `PWM_TMO_STEP);
    end
endfunction

// ------------------------------------------------------------
// input synchronisers
// ------------------------------------------------------------
reg [15:0] in_s1_r, in_s2_r;
reg scl_d_r, sda_d_r;
reg [5:0] fault_d_r;

wire scl_s = in_s2_r[0];
wire sda_s = in_s2_r[1];
wire group_one_gate_in_s = in_s2_r[2];
wire group_two_gate_in_s = in_s2_r[3];
wire [5:0] fault_s = in_s2_r[9:4];
wire short_s = in_s2_r[10];
wire open_s = in_s2_r[11];
wire [3:0] boost_flags_s = in_s2_r[15:12];

always @(posedge CLK_I)
begin
    if (RST_I)
    begin
        in_s1_r <= 16'h0003;
        in_s2_r <= 16'h0003;
        scl_d_r <= 1'b1;
        sda_d_r <= 1'b1;
        fault_d_r <= 6'h00;
    end
    else
    begin
        in_s1_r <= {OVERCURRENT_I, OVERVOLTAGE_I, OUTPUT_SHORT_I, OVERTEMP_I, STRING_OPEN_I, STRING_SHORT_I,
                    CHANNEL_FAULT_I, GROUP_TWO_GATE_IN_I, GROUP_ONE_GATE_IN_I, SDA_I, SCL_I};
        in_s2_r <= in_s1_r;
        scl_d_r <= scl_s;
        sda_d_r <= sda_s;
        fault_d_r <= fault_s;
    end
end

wire scl_rise = scl_s & ~scl_d_r;
wire scl_fall = ~scl_s & scl_d_r;
wire start_c = scl_s & scl_d_r & sda_d_r & ~sda_s;
wire stop_c = scl_s & scl_d_r & ~sda_d_r & sda_s;

// ------------------------------------------------------------
// register storage
// ------------------------------------------------------------
reg [7:0] pre_r, vout_r, peak_r, g1h_r, g1l_r, g2h_r;
reg [7:0] g2l_r, chen_r, mode_r, boost_r, led_r;

// ------------------------------------------------------------
// i2c target
// ------------------------------------------------------------
reg [3:0] state_r, bit_cnt_r;
reg [7:0] shreg_r, offset_r, rd_data;
reg rw_r, nack_r, sda_oe_r, sda_low_r;

always @*
begin
    case (offset_r)
        `OFS_PRECHARGE: rd_data = pre_r;
        `OFS_VOUT: rd_data = vout_r;
        `OFS_PEAK: rd_data = peak_r;
        `OFS_G1_HIGH: rd_data = g1h_r;
        `OFS_G1_LOW: rd_data = g1l_r;
        `OFS_G2_HIGH: rd_data = g2h_r;
        `OFS_G2_LOW: rd_data = g2l_r;
        `OFS_CH_EN: rd_data = chen_r;
        `OFS_MODE: rd_data = mode_r;
        `OFS_BOOST: rd_data = {boost_r[7], boost_flags_s, boost_r[2:0]};
        `OFS_LED: rd_data = led_r;
        default: rd_data = 8'h00;
    endcase
end

wire quiet = ~start_c & ~stop_c;
wire byte_in = scl_fall & (bit_cnt_r == 4'h8) & quiet;
wire wr_en = (state_r == ST_WDATA) & byte_in;
wire load = quiet & scl_fall & (((state_r == ST_ACK_ADDR) & rw_r) | ((state_r == ST_RACK) & ~nack_r));
wire led_read = load & (offset_r == `OFS_LED);

always @(posedge CLK_I)
begin
    if (RST_I)
    begin
        state_r <= ST_IDLE;
        bit_cnt_r <= 4'h0;
        shreg_r <= 8'h00;
        offset_r <= 8'h00;
        rw_r <= 1'b0;
        nack_r <= 1'b0;
        sda_oe_r <= 1'b0;
        sda_low_r <= 1'b0;
    end
    else
    begin
        sda_low_r <= 1'b0;
        if (start_c)
        begin
            // repeated start keeps the offset for a following read
            state_r <= ST_ADDR;
            bit_cnt_r <= 4'h0;
            sda_oe_r <= 1'b0;
        end
        else if (stop_c)
        begin
            state_r <= ST_IDLE;
            sda_oe_r <= 1'b0;
        end
        else if (load)
        begin
            shreg_r <= rd_data;
            sda_oe_r <= ~rd_data[7];
            offset_r <= offset_r + 8'h01;
            bit_cnt_r <= 4'h0;
            state_r <= ST_RDATA;
        end
        else
        begin
            case (state_r)
                ST_ADDR, ST_OFFS, ST_WDATA:
                begin
                    if (scl_rise && bit_cnt_r != 4'h8)
                    begin
                        shreg_r <= {shreg_r[6:0], sda_s};
                        bit_cnt_r <= bit_cnt_r + 4'h1;
                    end
                    else if (byte_in)
                    begin
                        sda_oe_r <= 1'b1;
                        if (state_r == ST_ADDR)
                        begin
                            if (shreg_r[7:1] == DEV_ADDR)
                            begin
                                rw_r <= shreg_r[0];
                                state_r <= ST_ACK_ADDR;
                            end
                            else
                            begin
                                sda_oe_r <= 1'b0;
                                state_r <= ST_IDLE;
                            end
                        end
                        else if (state_r == ST_OFFS)
                        begin
                            offset_r <= shreg_r;
                            state_r <= ST_ACK_OFFS;
                        end
                        else
                        begin
                            offset_r <= offset_r + 8'h01;
                            state_r <= ST_ACK_W;
                        end
                    end
                end
                ST_ACK_ADDR, ST_ACK_OFFS, ST_ACK_W:
                begin
                    if (scl_fall)
                    begin
                        sda_oe_r <= 1'b0;
                        bit_cnt_r <= 4'h0;
                        state_r <= (state_r == ST_ACK_ADDR) ? ST_OFFS : ST_WDATA;
                    end
                end
                ST_RDATA:
                begin
                    if (scl_fall)
                    begin
                        if (bit_cnt_r == 4'h7)
                        begin
                            sda_oe_r <= 1'b0;
                            state_r <= ST_RACK;
                        end
                        else
                        begin
                            shreg_r <= {shreg_r[6:0], 1'b0};
                            sda_oe_r <= ~shreg_r[6];
                            bit_cnt_r <= bit_cnt_r + 4'h1;
                        end
                    end
                end
                ST_RACK:
                begin
                    if (scl_rise)
                        nack_r <= sda_s;
                    else if (scl_fall)
                        state_r <= ST_IDLE;
                end
                default: state_r <= ST_IDLE;
            endcase
        end
    end
end

// ------------------------------------------------------------
// register writes and fault handling
// ------------------------------------------------------------
// faults are only seen on enabled channels, and win over a host write
wire [5:0] fault_ev = fault_s & ~fault_d_r & chen_r[5:0];
always @(posedge CLK_I)
begin
    if (RST_I)
    begin
        pre_r <= `RST_PRECHARGE;
        vout_r <= `RST_VOUT;
        peak_r <= `RST_PEAK;
        g1h_r <= `RST_G_HIGH;
        g1l_r <= `RST_G_LOW;
        g2h_r <= `RST_G_HIGH;
        g2l_r <= `RST_G_LOW;
        chen_r <= `RST_CH_EN;
        mode_r <= `RST_MODE;
        boost_r <= `RST_BOOST;
        led_r <= `RST_LED;
    end
    else
    begin
        if (wr_en)
        begin
            case (offset_r)
                `OFS_PRECHARGE: pre_r <= shreg_r;
                `OFS_VOUT: vout_r <= shreg_r;
                `OFS_PEAK: peak_r <= shreg_r;
                `OFS_G1_HIGH: g1h_r <= shreg_r;
                `OFS_G1_LOW: g1l_r <= shreg_r;
                `OFS_G2_HIGH: g2h_r <= shreg_r;
                `OFS_G2_LOW: g2l_r <= shreg_r;
                `OFS_CH_EN: chen_r <= shreg_r;
                `OFS_MODE: mode_r <= shreg_r;
                `OFS_BOOST: boost_r <= {shreg_r[7], 4'h0, shreg_r[2:0]};
                default: pre_r <= pre_r;
            endcase
        end
        if (led_read)
            led_r <= 8'h00;
        if (fault_ev != 6'h00)
        begin
            chen_r[5:0] <= (wr_en && offset_r == `OFS_CH_EN ? shreg_r[5:0] : chen_r[5:0]) & ~fault_ev;
            led_r <= (led_read ? 8'h00 : led_r) | {short_s, open_s, fault_ev};
            if (pre_r[`FAULT_SD_BIT])
                mode_r[`DEVICE_ON_INTERNAL_BIT] <= 1'b0;
        end
    end
end

// ------------------------------------------------------------
// pwm gating and sink drive
// ------------------------------------------------------------
reg [15:0] tick_cnt_r;
reg [5:0] sink_r;
reg tick_r;
wire gate1, gate2;

always @(posedge CLK_I)
begin
    if (RST_I)
    begin
        tick_cnt_r <= 16'h0000;
        tick_r <= 1'b0;
    end
    else
    begin
        tick_r <= (tick_cnt_r == TICK_LAST);
        tick_cnt_r <= (tick_cnt_r == TICK_LAST) ? 16'h0000 : tick_cnt_r + 16'h0001;
    end
end

pwm_on_time_gate #(.CNT_W(12)) u_gate_one (
    .clk_i(CLK_I), .rst_i(RST_I),
    .pwm_i(group_one_gate_in_s),
    .tick_i(tick_r),
    .limit_en_i(vout_r[`TMO_EN_BIT]),
    .limit_i(limit_ticks(vout_r[`TMO_LSB+2:`TMO_LSB])),
    .gate_o(gate1)
);

pwm_on_time_gate #(.CNT_W(12)) u_gate_two (
    .clk_i(CLK_I), .rst_i(RST_I),
    .pwm_i(group_two_gate_in_s),
    .tick_i(tick_r),
    .limit_en_i(vout_r[`TMO_EN_BIT]),
    .limit_i(limit_ticks(vout_r[`TMO_LSB+2:`TMO_LSB])),
    .gate_o(gate2)
);

always @(posedge CLK_I)
begin
    if (RST_I)
        sink_r <= 6'h00;
    else
        sink_r <= chen_r[5:0] & {6{mode_r[`DEVICE_ON_INTERNAL_BIT]}} & {{3{gate2}}, {3{gate1}}};
end

// ------------------------------------------------------------
// outputs, all straight from flip-flops
// ------------------------------------------------------------
assign SDA_O = sda_low_r;
assign SDA_OE_O = sda_oe_r;
assign SINK_DRIVE_O = sink_r;
assign SWITCH_FREQ_SEL_O = pre_r[`FSW_LSB+1:`FSW_LSB];
assign GATE_DRIVE_LEVEL_O = pre_r[2:0];
assign INITIAL_VOUT_SEL_O = vout_r[2:0];
assign INITIAL_PEAK_SEL_O = peak_r[2:0];
assign GROUP_ONE_CURRENT_CODE_O = {g1h_r[1:0], g1l_r};
assign GROUP_TWO_CURRENT_CODE_O = {g2h_r[1:0], g2l_r};
assign DRIVER_FAST_O = mode_r[`DRV_FAST_BIT];
assign DEVICE_ON_INTERNAL_O = mode_r[`DEVICE_ON_INTERNAL_BIT];
assign COMP_RESISTOR_SEL_O = mode_r[`COMP_LSB+2:`COMP_LSB];
assign LOOP_GAIN_SEL_O = mode_r[2:0];
assign SUPPLY_SOURCE_SEL_O = boost_r[`SUPPLY_BIT];
assign OVERVOLTAGE_LIMIT_SEL_O = boost_r[2:0];

endmodule // led_driver_i2c_register_bank
`default_nettype wire

// >>> led_bank_sva.sv
// port assertions of the led driver register bank
`timescale 1ns/100ps
`default_nettype none
module led_bank_sva (
    input wire logic CLK_I,
    input wire logic RST_I,
    input wire logic SCL_I,
    input wire logic SDA_O,
    input wire logic SDA_OE_O,
    input wire logic GROUP_ONE_GATE_IN_I,
    input wire logic GROUP_TWO_GATE_IN_I,
    input wire logic [5:0] SINK_DRIVE_O,
    input wire logic [1:0] SWITCH_FREQ_SEL_O,
    input wire logic [2:0] GATE_DRIVE_LEVEL_O,
    input wire logic [2:0] INITIAL_VOUT_SEL_O,
    input wire logic [2:0] INITIAL_PEAK_SEL_O,
    input wire logic [9:0] GROUP_ONE_CURRENT_CODE_O,
    input wire logic DEVICE_ON_INTERNAL_O
);
    default clocking cb @(posedge CLK_I);
    endclocking
    default disable iff (RST_I);
    // ----------------------------------------
    // bus pin and register outputs
    // ----------------------------------------
    sda_low_only_a: assert property (SDA_O == 1'b0) else $error("sda drives high");
    // the target may only move the data line while the clock is low
    sda_scl_low_a: assert property ($changed(SDA_OE_O) |-> !SCL_I) else $error("sda moved with scl high");
    rst_precharge_a: assert property ($fell(RST_I) |-> SWITCH_FREQ_SEL_O == 2'h2
        && GATE_DRIVE_LEVEL_O == 3'h3 && SDA_OE_O == 1'b0) else $error("bad reset precharge fields");
    rst_startup_a: assert property ($fell(RST_I) |-> INITIAL_VOUT_SEL_O == 3'h6
        && INITIAL_PEAK_SEL_O == 3'h0 && GROUP_ONE_CURRENT_CODE_O == 10'h2BC) else $error("bad reset startup");
    cfg_on_ack_a: assert property ($changed({GATE_DRIVE_LEVEL_O, SWITCH_FREQ_SEL_O, INITIAL_VOUT_SEL_O})
        |-> SDA_OE_O && !SCL_I) else $error("config changed outside a write ack");
    cur_on_ack_a: assert property ($changed({INITIAL_PEAK_SEL_O, GROUP_ONE_CURRENT_CODE_O})
        |-> SDA_OE_O) else $error("current code changed outside a write ack");
    // ----------------------------------------
    // sink gating
    // ----------------------------------------
    sink_dev_on_a: assert property ($rose(|SINK_DRIVE_O) |-> DEVICE_ON_INTERNAL_O) else $error("sink without enable");
    grp1_off_a: assert property ($fell(GROUP_ONE_GATE_IN_I) |-> ##[1:8] SINK_DRIVE_O[2:0] == 3'h0)
        else $error("group one stays on");
    grp2_off_a: assert property ($fell(GROUP_TWO_GATE_IN_I) |-> ##[1:8] SINK_DRIVE_O[5:3] == 3'h0)
        else $error("group two stays on");
    grp1_src_a: assert property ($rose(|SINK_DRIVE_O[2:0]) |-> $past(GROUP_ONE_GATE_IN_I, 2))
        else $error("group one on without its gate");
    cover property (GROUP_ONE_GATE_IN_I && $fell(SINK_DRIVE_O[0]));
    cover property ($rose(SDA_OE_O));
    cover property ($fell(DEVICE_ON_INTERNAL_O));
endmodule // led_bank_sva
bind led_driver_i2c_register_bank led_bank_sva u_sva (.CLK_I(CLK_I), .RST_I(RST_I), .SCL_I(SCL_I),
    .SDA_O(SDA_O), .SDA_OE_O(SDA_OE_O), .GROUP_ONE_GATE_IN_I(GROUP_ONE_GATE_IN_I),
    .GROUP_TWO_GATE_IN_I(GROUP_TWO_GATE_IN_I), .SINK_DRIVE_O(SINK_DRIVE_O),
    .SWITCH_FREQ_SEL_O(SWITCH_FREQ_SEL_O), .GATE_DRIVE_LEVEL_O(GATE_DRIVE_LEVEL_O),
    .INITIAL_VOUT_SEL_O(INITIAL_VOUT_SEL_O), .INITIAL_PEAK_SEL_O(INITIAL_PEAK_SEL_O),
    .GROUP_ONE_CURRENT_CODE_O(GROUP_ONE_CURRENT_CODE_O), .DEVICE_ON_INTERNAL_O(DEVICE_ON_INTERNAL_O));
`default_nettype wire

// >>> i2c_host_model.sv
// behavioural i2c host that reaches the register bank
`timescale 1ns/100ps
`default_nettype none
module i2c_host_model #(
    parameter logic [6:0] ADDR = 7'h28
) (
    input wire logic clk_i,
    input wire logic sda_i,
    output logic scl_o,
    output logic sda_o
);
    // both lines idle released; the clock stands still between frames
    initial
    begin
        scl_o = 1'b1;
        sda_o = 1'b1;
    end
    task automatic w(input int n);
        repeat (n) @(posedge clk_i);
    endtask
    // data moves mid-low so it never reads as a start or stop
    task automatic xbit(input logic b, output logic r);
        w(4);
        sda_o <= b;
        w(4);
        scl_o <= 1'b1;
        w(8);
        r = sda_i;
        scl_o <= 1'b0;
    endtask
    task automatic xbyte(input logic [7:0] d, output logic [7:0] q, output logic nk);
        for (int i = 7; i >= 0; i--) xbit(d[i], q[i]);
        xbit(1'b1, nk);
    endtask
    task automatic start;
        w(4);
        sda_o <= 1'b1;
        w(4);
        scl_o <= 1'b1;
        w(8);
        sda_o <= 1'b0;
        w(8);
        scl_o <= 1'b0;
    endtask
    task automatic stop;
        w(4);
        sda_o <= 1'b0;
        w(4);
        scl_o <= 1'b1;
        w(8);
        sda_o <= 1'b1;
        w(8);
    endtask
    task automatic wr(input logic [6:0] a, input logic [7:0] o, d, output logic nk);
        logic [7:0] q;
        logic n0, n1, n2;
        start;
        xbyte({a, 1'b0}, q, n0);
        xbyte(o, q, n1);
        xbyte(d, q, n2);
        stop;
        nk = n0 | n1 | n2;
    endtask
    // a single byte read ends with a host nack
    task automatic rd(input logic [7:0] o, output logic [7:0] d, output logic nk);
        logic [7:0] q;
        logic n0, n1, n2, n3;
        start;
        xbyte({ADDR, 1'b0}, q, n0);
        xbyte(o, q, n1);
        start;
        xbyte({ADDR, 1'b1}, q, n2);
        xbyte(8'hFF, d, n3);
        stop;
        nk = n0 | n1 | n2;
    endtask
endmodule // i2c_host_model
`default_nettype wire

// >>> led_driver_i2c_register_bank_bench.sv
// self-checking bench of the led driver register bank
`timescale 1ns/100ps
`default_nettype none
`include "led_bank_defs.vh"
module led_driver_i2c_register_bank_bench;
    logic clk = 1'b0, rst = 1'b1, group_one_gate_in = 1'b0, group_two_gate_in = 1'b0, sht = 1'b0, opn = 1'b0;
    logic [5:0] flt = 6'h00;
    logic [3:0] st = 4'h0;
    logic scl, sda_h, sdo, sdoe, don, drvf, sup;
    logic [5:0] sink;
    logic [1:0] switch_freq_sel;
    logic [2:0] gd, iv, ip, cmp, lpg, ovl;
    logic [9:0] g1c, g2c;
    logic [7:0] wv [10];
    logic nk;
    wire logic sda_w;
    int n_mismatch = 0, comparisons = 0;
    assign sda_w = sda_h & ~(sdoe & ~sdo);
    initial
    begin
        forever #5 clk = ~clk;
    end
    i2c_host_model #(.ADDR(`ADDR_VARIANT_A)) u_host (.clk_i(clk), .sda_i(sda_w), .scl_o(scl), .sda_o(sda_h));
    led_driver_i2c_register_bank #(.ADDR_SEL(0), .TICK_DIV(16'h0002)) u_dut (.CLK_I(clk), .RST_I(rst),
        .SCL_I(scl), .SDA_I(sda_w), .SDA_O(sdo), .SDA_OE_O(sdoe), .GROUP_ONE_GATE_IN_I(group_one_gate_in),
        .GROUP_TWO_GATE_IN_I(group_two_gate_in), .CHANNEL_FAULT_I(flt), .STRING_SHORT_I(sht), .STRING_OPEN_I(opn),
        .OVERCURRENT_I(st[3]), .OVERVOLTAGE_I(st[2]), .OUTPUT_SHORT_I(st[1]), .OVERTEMP_I(st[0]),
        .SINK_DRIVE_O(sink), .SWITCH_FREQ_SEL_O(switch_freq_sel), .GATE_DRIVE_LEVEL_O(gd), .INITIAL_VOUT_SEL_O(iv),
        .INITIAL_PEAK_SEL_O(ip), .GROUP_ONE_CURRENT_CODE_O(g1c), .GROUP_TWO_CURRENT_CODE_O(g2c),
        .DRIVER_FAST_O(drvf), .DEVICE_ON_INTERNAL_O(don), .COMP_RESISTOR_SEL_O(cmp), .LOOP_GAIN_SEL_O(lpg),
        .SUPPLY_SOURCE_SEL_O(sup), .OVERVOLTAGE_LIMIT_SEL_O(ovl));
    // ----------------------------------------
    // expectations and bus helpers
    // ----------------------------------------
    function automatic logic [7:0] rst_val(input logic [7:0] o);
        case (o)
            8'h00: return 8'h2B;
            8'h01: return 8'h5E;
            8'h03, 8'h05: return 8'h02;
            8'h04, 8'h06: return 8'hBC;
            8'h08: return 8'h13;
            8'h09: return 8'h06;
            default: return 8'h00;
        endcase
    endfunction
    // status bits of the converter register always show the live inputs
    function automatic logic [7:0] exp_rd(input logic [7:0] o, d);
        return (o == 8'h09) ? {d[7], st, d[2:0]} : d;
    endfunction
    task automatic chk(input string nm, input logic [9:0] e, g);
        comparisons++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wreg(input logic [7:0] o, d);
        u_host.wr(`ADDR_VARIANT_A, o, d, nk);
        chk("write ack", 10'h000, 10'(nk));
    endtask
    task automatic rchk(input logic [7:0] o, e);
        logic [7:0] d;
        u_host.rd(o, d, nk);
        chk("read ack", 10'h000, 10'(nk));
        chk($sformatf("reg %h", o), 10'(e), 10'(d));
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic test_done;
        $display("comparisons %0d n_mismatch %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    initial
    begin
        void'($urandom(32'hA9F17844));
        cyc(6);
        rst <= 1'b0;
        cyc(4);
        for (int o = 0; o < 17; o++) rchk(o[7:0], rst_val(o[7:0]));
        for (int c = 0; c < 4; c++)
        begin
            wreg(8'h00, {2'h0, c[1:0], 4'h3});
            chk("freq sel", 10'(c[1:0]), 10'(switch_freq_sel));
        end
        for (int o = 0; o < 10; o++)
        begin
            wv[o] = 8'($urandom);
            st <= 4'($urandom);
            wreg(o[7:0], wv[o]);
            rchk(o[7:0], exp_rd(o[7:0], wv[o]));
        end
        chk("gate drive", 10'(wv[0][2:0]), 10'(gd));
        chk("vout sel", 10'(wv[1][2:0]), 10'(iv));
        chk("peak sel", 10'(wv[2][2:0]), 10'(ip));
        chk("group one code", {wv[3][1:0], wv[4]}, g1c);
        chk("group two code", {wv[5][1:0], wv[6]}, g2c);
        chk("mode outputs", 10'(wv[8]), 10'({drvf, don, cmp, lpg}));
        chk("boost rw outputs", 10'({wv[9][7], wv[9][2:0]}), 10'({sup, ovl}));
        wreg(8'h0C, 8'hA5);
        rchk(8'h0C, 8'h00);
        wreg(8'h10, 8'hFF);
        rchk(8'h10, 8'h00);
        u_host.wr(`ADDR_VARIANT_B, 8'h00, 8'h00, nk);
        chk("foreign address nack", 10'h001, 10'(nk));
        rchk(8'h00, wv[0]);
        wreg(8'h00, 8'h2B);
        wreg(8'h01, 8'h40);
        wreg(8'h07, 8'h3F);
        wreg(8'h08, 8'h40);
        group_one_gate_in <= 1'b1;
        cyc(50);
        chk("group one on", 10'h007, 10'(sink));
        cyc(1300);
        chk("before limit", 10'h007, 10'(sink));
        cyc(100);
        chk("after limit", 10'h000, 10'(sink));
        group_two_gate_in <= 1'b1;
        cyc(50);
        chk("group two alone", 10'h038, 10'(sink));
        group_one_gate_in <= 1'b0;
        cyc(20);
        group_one_gate_in <= 1'b1;
        cyc(50);
        chk("resumed on rise", 10'h03F, 10'(sink));
        wreg(8'h01, 8'h00);
        group_one_gate_in <= 1'b0;
        group_two_gate_in <= 1'b0;
        cyc(20);
        group_one_gate_in <= 1'b1;
        group_two_gate_in <= 1'b1;
        cyc(1600);
        chk("limit disabled", 10'h03F, 10'(sink));
        sht <= 1'b1;
        flt <= 6'h01;
        cyc(10);
        flt <= 6'h00;
        cyc(10);
        chk("shutdown sinks", 10'h000, 10'(sink));
        chk("device on cleared", 10'h000, 10'(don));
        rchk(8'h07, 8'h3E);
        rchk(8'h08, 8'h00);
        rchk(8'h10, 8'h81);
        wreg(8'h00, 8'h23);
        wreg(8'h08, 8'h40);
        sht <= 1'b0;
        opn <= 1'b1;
        flt <= 6'h10;
        cyc(10);
        flt <= 6'h00;
        cyc(10);
        chk("channel five off", 10'h02E, 10'(sink));
        chk("device on kept", 10'h001, 10'(don));
        rchk(8'h08, 8'h40);
        rchk(8'h10, 8'h50);
        test_done;
    end
    initial
    begin
        cyc(90000);
        n_mismatch++;
        test_done;
    end
endmodule // led_driver_i2c_register_bank_bench
`default_nettype wire
